// ### design/cfs_fanout_ctrl.sv
/*
 Pin-strapped control of an eight-output clock fanout buffer:
 source select, crystal power, bank driver types, reference copy.
 Assumes all inputs are synchronous to core_clk; clock levels are
 sampled, not used as clocks.
*/
// Function
// - Select 00 diff0, 01 diff1, 1x crystal.
// - Crystal powered down when differential selected.
// - Crystal selected: start oscillator, feed outputs.
// - Crystal path: enabled outputs inverse of input.
// - Differential path is non-inverting.
// - Floating or shorted pair drives outputs low.
// - Each bank type code sets driver independently.
// - Reference output Hi-Z when enable is 0.
// - Reference output is non-inverted selected clock.
// - Reference enable resynchronised to selected clock.
// - Reference drives within 3 clock cycles.
// - Reference releases within 3 clock cycles.
`timescale 1ns/1ps
`include "cfs_map.svh"

module cfs_fanout_ctrl
	import cfs_pkg::*;
#(
	parameter int OSC_START_CYCLES = `CFS_OSC_START_DEF
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,

	// Strap pins
	input wire logic [1:0] input_source_select,
	input wire cfs_drv_t bank_a_driver_type,
	input wire cfs_drv_t bank_b_driver_type,
	input wire logic reference_output_enable,

	// Clock inputs, sampled as levels
	input wire cfs_diff_t diff_clock_input_0,
	input wire cfs_diff_t diff_clock_input_1,
	input wire logic crystal_osc_input,

	// Crystal oscillator control and status
	output logic crystal_osc_power_en,
	output logic crystal_osc_ready,

	// Differential output banks
	output cfs_bank_out_t bank_a_out,
	output cfs_bank_out_t bank_b_out,

	// Single-ended reference copy
	output logic reference_copy_output,
	output logic reference_copy_output_oe
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	localparam int OSC_CNT_MAX = (1 << `CFS_OSC_CNT_W) - 1;

	generate
		if (OSC_START_CYCLES < 1 || OSC_START_CYCLES > OSC_CNT_MAX) begin : g_bad_osc
			$error("OSC_START_CYCLES out of range");
		end
	endgenerate

	localparam logic [`CFS_OSC_CNT_W-1:0] OSC_START = OSC_START_CYCLES[`CFS_OSC_CNT_W-1:0];

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_s1_q;
	logic rst_s2_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	logic rst_sync_n;
	assign rst_sync_n = rst_s2_q;

	// ----------------------------------------
	// Decoding helpers
	// ----------------------------------------

	// Floating and shorted pairs both look like no differential swing
	function automatic logic diff_level(input cfs_diff_t pair);
		diff_level = !pair.floating && pair.pos && !pair.neg;
	endfunction

	function automatic logic xtal_selected(input logic [1:0] sel);
		xtal_selected = sel[`CFS_SEL_XTAL_BIT];
	endfunction

	function automatic logic bank_driven(input cfs_drv_t mode);
		bank_driven = (mode != CFS_DRV_HIZ_E);
	endfunction

	// ----------------------------------------
	// Source selection
	// ----------------------------------------
	logic diff0_level;
	logic diff1_level;
	logic sel_xtal;
	logic src_raw;

	assign diff0_level = diff_level(diff_clock_input_0);
	assign diff1_level = diff_level(diff_clock_input_1);
	assign sel_xtal = xtal_selected(input_source_select);

	// Lower select bit is a don't-care once the crystal is chosen
	always_comb begin
		if (sel_xtal) begin
			src_raw = crystal_osc_input;
		end else if (input_source_select[`CFS_SEL_LOW_BIT]) begin
			src_raw = diff1_level;
		end else begin
			src_raw = diff0_level;
		end
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	cfs_main_state_t s_q;
	cfs_main_state_t s_d;
	logic src_rise;
	logic ref_drive;

	// Edge of the sampled selected clock; feeds the enable synchroniser
	assign src_rise = s_q.src_raw && !s_q.src_prev;

	always_comb begin
		s_d = s_q;

		// Selected clock history
		s_d.src_raw = src_raw;
		s_d.src_prev = s_q.src_raw;

		// Crystal power follows the selection directly
		s_d.osc_pwr = sel_xtal;

		// Start-up count; restarts each time the crystal is re-selected
		if (!sel_xtal) begin
			s_d.osc_cnt = '0;
			s_d.osc_ready = 1'b0;
		end else if (!s_q.osc_ready) begin
			if (s_q.osc_cnt >= OSC_START - 1'b1) begin
				s_d.osc_ready = 1'b1;
			end else begin
				s_d.osc_cnt = s_q.osc_cnt + 1'b1;
			end
		end

		// Level distributed to both banks
		if (sel_xtal) begin
			// Held low until the oscillator has settled
			s_d.bank_level = s_q.osc_ready && !crystal_osc_input;
		end else begin
			s_d.bank_level = src_raw;
		end

		// Bank modes, each from its own strap
		s_d.mode_a = bank_a_driver_type;
		s_d.mode_b = bank_b_driver_type;

		// Reference copy is never inverted, even on the crystal path
		s_d.ref_data = src_raw;
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			s_q <= '{
				src_raw: 1'b0,
				src_prev: 1'b0,
				osc_pwr: 1'b0,
				osc_cnt: '0,
				osc_ready: 1'b0,
				bank_level: 1'b0,
				mode_a: CFS_DRV_HIZ_E,
				mode_b: CFS_DRV_HIZ_E,
				ref_data: 1'b0
			};
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// Reference enable synchroniser
	// ----------------------------------------
	cfs_ref_enable_sync u_ref_sync (
		.core_clk(core_clk),
		.rst_sync_n(rst_sync_n),
		.src_level(s_q.src_raw),
		.src_rise(src_rise),
		.enable(reference_output_enable),
		.drive(ref_drive)
	);

	// The pad drives only from the synchronised enable, never the raw strap
	assign reference_copy_output_oe = ref_drive;
	assign reference_copy_output = ref_drive && s_q.ref_data;

	// ----------------------------------------
	// Crystal status
	// ----------------------------------------
	assign crystal_osc_power_en = s_q.osc_pwr;
	assign crystal_osc_ready = s_q.osc_ready;

	// ----------------------------------------
	// Output banks
	// ----------------------------------------
	logic bank_a_on;
	logic bank_b_on;

	// A Hi-Z bank also stops toggling, which is where the power saving is
	assign bank_a_on = bank_driven(s_q.mode_a);
	assign bank_b_on = bank_driven(s_q.mode_b);

	assign bank_a_out.mode = s_q.mode_a;
	assign bank_b_out.mode = s_q.mode_b;

	genvar gi;
	generate
		for (gi = 0; gi < `CFS_OUTS_PER_BANK; gi++) begin : g_out
			assign bank_a_out.oe[gi] = bank_a_on;
			assign bank_a_out.pos[gi] = bank_a_on && s_q.bank_level;
			assign bank_a_out.neg[gi] = bank_a_on && !s_q.bank_level;
			assign bank_b_out.oe[gi] = bank_b_on;
			assign bank_b_out.pos[gi] = bank_b_on && s_q.bank_level;
			assign bank_b_out.neg[gi] = bank_b_on && !s_q.bank_level;
		end
	endgenerate

endmodule // cfs_fanout_ctrl

// ### common/cfs_map.svh
/*
 Named constants of the clock fanout select/enable block.
 Assumes inclusion by bare name; holds definitions only.
*/
`ifndef CFS_MAP_SVH
`define CFS_MAP_SVH

// ----------------------------------------
// Input source select
// ----------------------------------------
`define CFS_SEL_XTAL_BIT 1
`define CFS_SEL_LOW_BIT 0
`define CFS_SEL_DIFF0 2'h0
`define CFS_SEL_DIFF1 2'h1

// ----------------------------------------
// Bank driver type codes
// ----------------------------------------
`define CFS_DRV_STD1 2'h0
`define CFS_DRV_STD2 2'h1
`define CFS_DRV_CURR 2'h2
`define CFS_DRV_HIZ 2'h3

// ----------------------------------------
// Sizes and timing
// ----------------------------------------
`define CFS_OUTS_PER_BANK 4
`define CFS_OSC_CNT_W 16
`define CFS_OSC_START_DEF 16
`define CFS_ENABLE_LATENCY_CYC 3
`define CFS_DISABLE_LATENCY_CYC 3
`define CFS_XTAL_EXT_MAX_MHZ 250

`endif

// ### common/cfs_pkg.sv
/*
 Types of the clock fanout select/enable block.
 Assumes cfs_map.svh is on the include path.
*/
`include "cfs_map.svh"

package cfs_pkg;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef enum logic [1:0] {
		CFS_DRV_STD1_E = `CFS_DRV_STD1,
		CFS_DRV_STD2_E = `CFS_DRV_STD2,
		CFS_DRV_CURR_E = `CFS_DRV_CURR,
		CFS_DRV_HIZ_E = `CFS_DRV_HIZ
	} cfs_drv_t;

	typedef struct packed {
		logic pos;
		logic neg;
		logic floating;
	} cfs_diff_t;

	typedef struct packed {
		cfs_drv_t mode;
		logic [`CFS_OUTS_PER_BANK-1:0] pos;
		logic [`CFS_OUTS_PER_BANK-1:0] neg;
		logic [`CFS_OUTS_PER_BANK-1:0] oe;
	} cfs_bank_out_t;

	// ----------------------------------------
	// Enable synchroniser states
	// ----------------------------------------
	typedef enum logic [3:0] {
		CFS_REF_OFF = 4'b0001,
		CFS_REF_ARM_ON = 4'b0010,
		CFS_REF_ON = 4'b0100,
		CFS_REF_ARM_OFF = 4'b1000
	} cfs_ref_st_t;

	typedef struct packed {
		logic en_s1;
		logic en_s2;
		cfs_ref_st_t st;
		logic drive;
	} cfs_sync_state_t;

	typedef struct packed {
		logic src_raw;
		logic src_prev;
		logic osc_pwr;
		logic [`CFS_OSC_CNT_W-1:0] osc_cnt;
		logic osc_ready;
		logic bank_level;
		cfs_drv_t mode_a;
		cfs_drv_t mode_b;
		logic ref_data;
	} cfs_main_state_t;

endpackage

// ### design/cfs_ref_enable_sync.sv
/*
 Reference output enable synchroniser.
 Assumes src_rise marks each rising edge of the selected clock level
 and src_level is the registered selected clock level.
*/
`timescale 1ns/1ps
`include "cfs_map.svh"

module cfs_ref_enable_sync
	import cfs_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_sync_n,
	// Selected clock view
	input wire logic src_level,
	input wire logic src_rise,
	// Strap and result
	input wire logic enable,
	output logic drive
);

	cfs_sync_state_t s_q;
	cfs_sync_state_t s_d;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		// Two stages clocked by the selected clock edges only
		if (src_rise) begin
			s_d.en_s1 = enable;
			s_d.en_s2 = s_q.en_s1;
		end
		case (s_q.st)
			CFS_REF_OFF: begin
				if (s_q.en_s2) s_d.st = CFS_REF_ARM_ON;
			end
			CFS_REF_ARM_ON: begin
				if (!s_q.en_s2) s_d.st = CFS_REF_OFF;
				else if (!src_level) s_d.st = CFS_REF_ON;
			end
			CFS_REF_ON: begin
				if (!s_q.en_s2) s_d.st = CFS_REF_ARM_OFF;
			end
			CFS_REF_ARM_OFF: begin
				if (s_q.en_s2) s_d.st = CFS_REF_ON;
				else if (!src_level) s_d.st = CFS_REF_OFF;
			end
			default: begin
				s_d.st = CFS_REF_OFF;
			end
		endcase
		// Drive holds until the low phase so a high pulse is never cut
		s_d.drive = (s_d.st == CFS_REF_ON) || (s_d.st == CFS_REF_ARM_OFF);
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			s_q <= '{en_s1: 1'b0, en_s2: 1'b0, st: CFS_REF_OFF, drive: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign drive = s_q.drive;

endmodule // cfs_ref_enable_sync

// ### verif/cfs_src_model.sv
/*
 Upstream clock source model.
 Assumes core_clk from the bench; levels move at falling edges.
*/
`timescale 1ns/1ps
module cfs_src_model
	import cfs_pkg::*;
#(
	parameter int HALF = 4
)
(
	// Control
	input wire logic core_clk,
	input wire logic run,
	input wire logic lvl,
	input wire logic flt,
	// Source levels
	output cfs_diff_t diff0,
	output cfs_diff_t diff1,
	output logic xtal
);
	logic ph_q = 1'b0;
	int cnt_q = 0;
	logic v;
	always @(negedge core_clk) begin
		cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
		if (cnt_q == HALF - 1) begin
			ph_q <= ~ph_q;
		end
	end
	assign v = run ? ph_q : lvl;
	// A floating pair is shown with both legs equal
	assign diff0 = flt ? 3'b111 : {v, ~v, 1'b0};
	assign diff1 = {~v, v, 1'b0};
	// Far below the single-ended ceiling of the crystal pin
	assign xtal = v;
endmodule // cfs_src_model

// ### verif/cfs_fanout_ctrl_props.sv
/*
 Port checker of the fanout control block.
 Assumes the source half period is SRC_HALF core cycles.
*/
`timescale 1ns/1ps
module cfs_fanout_ctrl_props
	import cfs_pkg::*;
#(
	parameter int SRC_HALF = 4
)
(
	// Inputs
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [1:0] input_source_select,
	input wire cfs_drv_t bank_a_driver_type,
	input wire logic reference_output_enable,
	input wire cfs_diff_t diff_clock_input_0,
	input wire logic crystal_osc_input,
	// Outputs
	input wire logic crystal_osc_power_en,
	input wire logic crystal_osc_ready,
	input wire cfs_bank_out_t bank_a_out,
	input wire cfs_bank_out_t bank_b_out,
	input wire logic reference_copy_output,
	input wire logic reference_copy_output_oe
);
	// Three source cycles plus synchroniser slack
	localparam int LIM = 6 * SRC_HALF + 6;
	int on_q;
	int off_q;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			on_q <= 0;
			off_q <= 0;
		end else begin
			on_q <= (reference_output_enable && !reference_copy_output_oe) ? on_q + 1 : 0;
			off_q <= (!reference_output_enable && reference_copy_output_oe) ? off_q + 1 : 0;
		end
	end
	a_diff_high: assert property (
		(input_source_select == 2'h0 && diff_clock_input_0 == 3'b100
		&& bank_a_driver_type != CFS_DRV_HIZ_E) [*6] |=> bank_a_out.pos == 4'hf) else $error("diff high lost");
	a_float_low: assert property (
		(input_source_select == 2'h0 && diff_clock_input_0.floating) [*6] |=> bank_a_out.pos == 4'h0)
		else $error("floating not low");
	a_xtal_inverse: assert property (
		(input_source_select[1] && crystal_osc_ready && !crystal_osc_input
		&& bank_a_driver_type != CFS_DRV_HIZ_E) [*4] |=> bank_a_out.pos == 4'hf) else $error("crystal not inverted");
	a_xtal_off: assert property (
		(!input_source_select[1]) [*4] |=> !crystal_osc_power_en) else $error("crystal powered");
	a_xtal_start: assert property (
		input_source_select[1] [*5] |=> crystal_osc_power_en) else $error("crystal not powered");
	a_mode_track: assert property (
		$stable(bank_a_driver_type) [*6] |=> bank_a_out.mode == $past(bank_a_driver_type)) else $error("mode wrong");
	a_hiz_quiet: assert property (
		bank_b_out.mode == CFS_DRV_HIZ_E |-> bank_b_out.oe == 4'h0 && bank_b_out.pos == 4'h0)
		else $error("hiz bank driven");
	a_ref_off_low: assert property (
		!reference_copy_output_oe |-> !reference_copy_output) else $error("ref data while off");
	a_enable_bound: assert property (on_q <= LIM) else $error("ref enable late");
	a_disable_bound: assert property (off_q <= LIM) else $error("ref disable late");
	c_ref_on: cover property ($rose(reference_copy_output_oe));
	c_ref_off: cover property ($fell(reference_copy_output_oe));
	c_xtal_up: cover property ($rose(crystal_osc_ready));
endmodule // cfs_fanout_ctrl_props
bind cfs_fanout_ctrl cfs_fanout_ctrl_props #(.SRC_HALF(4)) cfs_fanout_ctrl_props_inst (.*);

// ### verif/tb.sv
/*
 Self-checking bench of the fanout control block.
 Assumes the source model and the checker bind are compiled too.
*/
`timescale 1ns/1ps
module tb;
	import cfs_pkg::*;
	localparam int HALF = 4;
	logic core_clk;
	logic rst_n;
	logic [1:0] sel;
	cfs_drv_t typ_a;
	cfs_drv_t typ_b;
	logic ref_en;
	logic run;
	logic lvl;
	logic flt;
	cfs_diff_t d0;
	cfs_diff_t d1;
	logic xt;
	logic pwr;
	logic rdy;
	cfs_bank_out_t ba;
	cfs_bank_out_t bb;
	logic rco;
	logic rco_oe;
	int num_errors = 0;
	int cmp_count = 0;

	cfs_src_model #(.HALF(HALF)) cfs_src_model_inst (.core_clk(core_clk), .run(run), .lvl(lvl), .flt(flt),
		.diff0(d0), .diff1(d1), .xtal(xt));
	// Short start-up count keeps the crystal scenario brief
	cfs_fanout_ctrl #(.OSC_START_CYCLES(2)) cfs_fanout_ctrl_inst (.core_clk(core_clk), .rst_n(rst_n),
		.input_source_select(sel), .bank_a_driver_type(typ_a), .bank_b_driver_type(typ_b),
		.reference_output_enable(ref_en), .diff_clock_input_0(d0), .diff_clock_input_1(d1),
		.crystal_osc_input(xt), .crystal_osc_power_en(pwr), .crystal_osc_ready(rdy),
		.bank_a_out(ba), .bank_b_out(bb), .reference_copy_output(rco), .reference_copy_output_oe(rco_oe));

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("errors=%0d compares=%0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic wait_oe(input logic v);
		int i;
		// Three source cycles plus sampling slack, as in the checker
		for (i = 0; i < 6 * HALF + 6 && rco_oe !== v; i++) begin
			cyc(1);
		end
		if (rco_oe !== v) begin
			check(rco_oe, v);
			finish_test();
		end
	endtask

	function automatic logic [15:0] bank_exp(input cfs_drv_t t, input logic l);
		logic [3:0] m;
		m = (t == CFS_DRV_HIZ_E) ? 4'h0 : 4'hf;
		return {2'h0, t, m & {4{l}}, m & {4{~l}}, m};
	endfunction

	// Every type code on both banks while the two pairs carry opposite levels
	task automatic t_types();
		int i;
		for (i = 0; i < 4; i++) begin
			sel = {1'b0, i[0]};
			typ_a = cfs_drv_t'(i);
			typ_b = cfs_drv_t'(3 - i);
			// Long enough for the checker's six-cycle antecedents
			cyc(8);
			check({2'h0, ba}, bank_exp(typ_a, ~i[0]));
			check({2'h0, bb}, bank_exp(typ_b, ~i[0]));
			check(pwr, 1'b0);
		end
	endtask

	task automatic t_float();
		sel = 2'h0;
		typ_a = CFS_DRV_STD1_E;
		flt = 1'b1;
		cyc(8);
		check({2'h0, ba}, bank_exp(typ_a, 1'b0));
		flt = 1'b0;
	endtask

	// Lower select bit flips while the crystal stays selected
	task automatic t_xtal();
		int i;
		for (i = 0; i < 2; i++) begin
			sel = {1'b1, i[0]};
			lvl = i[0];
			cyc(8);
			check({pwr, rdy}, 2'h3);
			check({2'h0, ba}, bank_exp(typ_a, ~lvl));
		end
		sel = 2'h1;
		cyc(4);
		check({pwr, rdy}, 2'h0);
	endtask

	task automatic t_ref();
		int i;
		logic hi;
		logic lo;
		logic inv;
		hi = 1'b0;
		lo = 1'b0;
		inv = 1'b0;
		run = 1'b1;
		sel = 2'h0;
		cyc(4);
		check(rco_oe, 1'b0);
		ref_en = 1'b1;
		wait_oe(1'b1);
		for (i = 0; i < 4 * HALF; i++) begin
			cyc(1);
			hi |= rco;
			lo |= !rco;
			// Source level moves only after this read, so it is the level sampled at the last rising edge
			inv |= (rco !== d0.pos);
		end
		check({hi, lo}, 2'h3);
		check(inv, 1'b0);
		ref_en = 1'b0;
		wait_oe(1'b0);
		check(rco, 1'b0);
		run = 1'b0;
	endtask

	initial begin
		rst_n = 1'b0;
		sel = 2'h0;
		typ_a = CFS_DRV_HIZ_E;
		typ_b = CFS_DRV_HIZ_E;
		ref_en = 1'b0;
		run = 1'b0;
		lvl = 1'b1;
		flt = 1'b0;
		cyc(2);
		rst_n = 1'b1;
		cyc(3);
		t_types();
		t_float();
		t_xtal();
		t_ref();
		finish_test();
	end
endmodule // tb
